// ### src/exec_pkg.sv
/*
 * Shared constants for the branch, call and move execution block: opcodes,
 * instruction lengths, special register addresses and state codes.
 * Assumes an 8-bit core with a 16-bit program space and 8-bit internal data space.
 */
package exec_pkg;
    // Opcodes.
    localparam logic [7:0] OP_ACC_ZERO_BRANCH = 8'h60;
    localparam logic [7:0] OP_ACC_NONZERO_BRANCH = 8'h70;
    localparam logic [7:0] OP_LONG_CALL = 8'h12;
    localparam logic [7:0] OP_LONG_JUMP = 8'h02;
    localparam logic [7:0] OP_POINTER_LOAD = 8'h90;
    localparam logic [7:0] OP_CODE_READ_DP = 8'h93;
    localparam logic [7:0] OP_CODE_READ_PC = 8'h83;
    localparam logic [7:0] OP_C_FROM_BIT = 8'hA2;
    localparam logic [7:0] OP_BIT_FROM_C = 8'h92;
    localparam logic [7:0] OP_A_DIR = 8'hE5;
    localparam logic [7:0] OP_A_IMM = 8'h74;
    localparam logic [7:0] OP_DIR_A = 8'hF5;
    localparam logic [7:0] OP_DIR_DIR = 8'h85;
    localparam logic [7:0] OP_DIR_IMM = 8'h75;
    // Opcode groups compared on the upper five or seven bits.
    localparam logic [4:0] GRP_A_REG = 5'h1D;
    localparam logic [4:0] GRP_REG_A = 5'h1F;
    localparam logic [4:0] GRP_REG_DIR = 5'h15;
    localparam logic [4:0] GRP_REG_IMM = 5'h0F;
    localparam logic [4:0] GRP_DIR_REG = 5'h11;
    localparam logic [6:0] GRP_A_IND = 7'h73;
    localparam logic [6:0] GRP_IND_A = 7'h7B;
    localparam logic [6:0] GRP_IND_DIR = 7'h53;
    localparam logic [6:0] GRP_IND_IMM = 7'h3B;
    localparam logic [6:0] GRP_DIR_IND = 7'h43;
    // Lengths and special addresses.
    localparam logic [15:0] LEN_ONE = 16'h0001;
    localparam logic [15:0] LEN_TWO = 16'h0002;
    localparam logic [15:0] LEN_THREE = 16'h0003;
    localparam logic [7:0] ACC_DIRECT_ADDR = 8'hE0;
    localparam logic [7:0] SP_RESET = 8'h07;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam int BANK_SEL_W = 3;
    localparam int ADDR_W = 16;

    typedef enum logic [4:0] {
        ST_FETCH = 5'b00001,
        ST_OPER1 = 5'b00010,
        ST_OPER2 = 5'b00100,
        ST_EXEC = 5'b01000,
        ST_PUSH_HI = 5'b10000
    } exec_state_t;
endpackage

// ### src/opcode_length.sv
/*
 * Returns the byte count of an opcode and whether this block knows it.
 * Assumes a registered opcode from the same clock domain.
 */
`timescale 1ns/100ps
module opcode_length
    import exec_pkg::*;
(
    input wire logic [7:0] opcode_i,
    output logic [1:0] length_o,
    output logic known_o
);
    always_comb
    begin
        length_o = 2'd1;
        known_o = 1'b1;
        if (opcode_i == OP_LONG_CALL || opcode_i == OP_LONG_JUMP || opcode_i == OP_POINTER_LOAD
            || opcode_i == OP_DIR_DIR || opcode_i == OP_DIR_IMM)
        begin
            length_o = 2'd3;
        end
        else if (opcode_i == OP_ACC_ZERO_BRANCH || opcode_i == OP_ACC_NONZERO_BRANCH
            || opcode_i == OP_C_FROM_BIT || opcode_i == OP_BIT_FROM_C || opcode_i == OP_A_DIR
            || opcode_i == OP_A_IMM || opcode_i == OP_DIR_A
            || opcode_i[7:3] == GRP_REG_DIR || opcode_i[7:3] == GRP_REG_IMM
            || opcode_i[7:3] == GRP_DIR_REG || opcode_i[7:1] == GRP_IND_DIR
            || opcode_i[7:1] == GRP_IND_IMM || opcode_i[7:1] == GRP_DIR_IND)
        begin
            length_o = 2'd2;
        end
        else if (opcode_i == OP_CODE_READ_DP || opcode_i == OP_CODE_READ_PC
            || opcode_i[7:3] == GRP_A_REG || opcode_i[7:3] == GRP_REG_A
            || opcode_i[7:1] == GRP_A_IND || opcode_i[7:1] == GRP_IND_A)
        begin
            length_o = 2'd1;
        end
        else
        begin
            known_o = 1'b0;
        end
    end
endmodule

// ### src/code_addr_adder.sv
/*
 * Forms a program memory address as an unsigned accumulator plus a 16-bit base.
 * Assumes both operands are stable for the cycle in which the sum is used.
 */
`timescale 1ns/100ps
module code_addr_adder
    import exec_pkg::*;
(
    input wire logic [15:0] base_i,
    input wire logic [7:0] acc_i,
    output logic [15:0] sum_o
);
    // Full-width sum so a carry out of the low byte reaches the high byte.
    assign sum_o = base_i + {BYTE_ZERO, acc_i}; // (RULE_18)
endmodule

// ### src/branch_move_exec.sv
/*
 * Fetches and executes conditional accumulator branches, long call and jump,
 * byte and bit moves, pointer load and code table reads.
 * Assumes single-cycle synchronous program memory reads, combinational internal
 * data reads and bit reads, and write ports that store on the cycle they are strobed.
 */
`timescale 1ns/100ps

// Behaviour
// (RULE_01) Branch when accumulator holds any set bit.
// (RULE_02) Branch target: PC plus two plus displacement.
// (RULE_03) Branch when accumulator is entirely zero.
// (RULE_04) Conditional branches change no accumulator or flag.
// (RULE_05) Call return address is PC plus three.
// (RULE_06) Push low then high, stack pointer plus two.
// (RULE_07) Call loads PC from bytes two, three.
// (RULE_08) Long jump loads PC high then low.
// (RULE_09) Byte move copies source, nothing else changes.
// (RULE_10) Fifteen byte move operand pairings supported.
// (RULE_11) Direct accumulator into accumulator is invalid.
// (RULE_12) Direct-to-direct: source byte two, destination three.
// (RULE_13) Bit move between carry and addressed bit.
// (RULE_14) Pointer load: byte two high, three low.
// (RULE_15) Code read: accumulator plus sixteen-bit base.
// (RULE_16) PC base advanced past instruction first.
// (RULE_17) Pointer base stays unaltered.
// (RULE_18) Code address sum is full sixteen bits.
// (RULE_19) Low opcode bits select bank or pointer register.
// (RULE_20) Customary opcodes for long jump, register move.
module branch_move_exec
    import exec_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    output logic [15:0] code_addr_o,
    input wire logic [7:0] code_data_i,
    output logic [7:0] data_raddr_o,
    input wire logic [7:0] data_rdata_i,
    output logic data_we_o,
    output logic [7:0] data_waddr_o,
    output logic [7:0] data_wdata_o,
    output logic [7:0] bit_addr_o,
    input wire logic bit_rdata_i,
    output logic bit_we_o,
    output logic bit_wdata_o,
    input wire logic [1:0] bank_i,
    output logic [7:0] accumulator_o,
    output logic carry_o,
    output logic [15:0] data_pointer_o,
    output logic [7:0] stack_pointer_o,
    output logic [15:0] pc_o,
    output logic invalid_o
);
    exec_state_t state_r;
    logic [7:0] op_r;
    logic [7:0] b2_r;
    logic [7:0] b3_r;
    logic [15:0] pc_r;
    logic [7:0] acc_r;
    logic carry_r;
    logic [15:0] data_pointer_r;
    logic [7:0] sp_r;
    logic [15:0] ret_r;
    logic code_phase_r;
    logic invalid_r;
    logic [7:0] ptr_val_r;
    logic [1:0] op_len;
    logic op_known;
    logic [15:0] next_pc;
    logic [15:0] rel_target;
    logic [15:0] table_addr;
    logic [15:0] table_base;
    logic [15:0] fetch_addr;
    logic is_table_read;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode helpers.

    // Register forms pick from the bank with the low three opcode bits.
    function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [7:0] op);
        bank_addr = {3'b000, bank, op[BANK_SEL_W-1:0]}; // (RULE_19)
    endfunction

    // Indirect forms pick pointer register zero or one with the lowest opcode bit.
    function automatic logic [7:0] ptr_addr(input logic [1:0] bank, input logic [7:0] op);
        ptr_addr = {3'b000, bank, 2'b00, op[0]}; // (RULE_19)
    endfunction

    // Indirect forms read their pointer register before the execute cycle.
    function automatic logic ind_form(input logic [7:0] op);
        ind_form = op[7:1] == GRP_A_IND || op[7:1] == GRP_DIR_IND || op[7:1] == GRP_IND_A
            || op[7:1] == GRP_IND_DIR || op[7:1] == GRP_IND_IMM; // (RULE_19)
    endfunction

    opcode_length u_len (
        .opcode_i(op_r),
        .length_o(op_len),
        .known_o(op_known)
    );

    assign next_pc = pc_r + {14'h0000, op_len};
    // Displacement is sign-extended and added to the already advanced PC.
    assign rel_target = next_pc + {{8{b2_r[7]}}, b2_r}; // (RULE_02)
    assign is_table_read = (op_r == OP_CODE_READ_DP) || (op_r == OP_CODE_READ_PC);
    // PC base is the following instruction; pointer base is only read.
    assign table_base = (op_r == OP_CODE_READ_PC) ? pc_r + LEN_ONE : data_pointer_r; // (RULE_16) (RULE_17)

    code_addr_adder u_add (
        .base_i(table_base),
        .acc_i(acc_r),
        .sum_o(table_addr) // (RULE_15)
    );

    always_comb
    begin
        fetch_addr = pc_r;
        if (state_r == ST_OPER1)
        begin
            fetch_addr = pc_r + LEN_ONE;
        end
        else if (state_r == ST_OPER2)
        begin
            fetch_addr = pc_r + LEN_TWO;
        end
        else if (state_r == ST_EXEC && is_table_read)
        begin
            fetch_addr = table_addr;
        end
    end

    assign code_addr_o = fetch_addr;

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer. The opcode byte arrives the cycle after its address, so ST_FETCH waits a cycle
    // for it, and ST_OPER2 and ST_PUSH_HI latch the byte requested by the state before them.

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            state_r <= ST_FETCH;
            op_r <= BYTE_ZERO;
            b2_r <= BYTE_ZERO;
            b3_r <= BYTE_ZERO;
            code_phase_r <= 1'b0;
            ptr_val_r <= BYTE_ZERO;
        end
        else
        begin
            case (state_r)
                ST_FETCH:
                begin
                    code_phase_r <= 1'b1;
                    if (code_phase_r)
                    begin
                        op_r <= code_data_i;
                        state_r <= ST_OPER1;
                        code_phase_r <= 1'b0;
                    end
                end
                ST_OPER1:
                begin
                    state_r <= (op_len == 2'd1) ? ST_EXEC : ST_OPER2;
                    // The pointer is read here, so execute can spend the single read
                    // port on the byte that it points at.
                    if (ind_form(op_r))
                    begin
                        ptr_val_r <= data_rdata_i;
                    end
                end
                ST_OPER2:
                begin
                    b2_r <= code_data_i;
                    state_r <= ST_EXEC;
                    if (op_len == 2'd3)
                    begin
                        state_r <= ST_PUSH_HI;
                    end
                end
                ST_PUSH_HI:
                begin
                    // Used here as the third-byte capture stage before execution.
                    b3_r <= code_data_i;
                    state_r <= ST_EXEC;
                end
                ST_EXEC:
                begin
                    if (is_table_read && !code_phase_r)
                    begin
                        code_phase_r <= 1'b1;
                    end
                    else if (op_r == OP_LONG_CALL && !code_phase_r)
                    begin
                        code_phase_r <= 1'b1;
                    end
                    else
                    begin
                        code_phase_r <= 1'b0;
                        state_r <= ST_FETCH;
                    end
                end
                default:
                begin
                    state_r <= ST_FETCH;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Program counter and return address.

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            pc_r <= PC_RESET;
            ret_r <= PC_RESET;
        end
        else if (state_r == ST_PUSH_HI)
        begin
            // Captured before execute so that the first push already sees it.
            ret_r <= pc_r + LEN_THREE; // (RULE_05)
        end
        else if (state_r == ST_EXEC && !(is_table_read || op_r == OP_LONG_CALL)
            || state_r == ST_EXEC && code_phase_r)
        begin
            if (op_r == OP_ACC_NONZERO_BRANCH)
            begin
                pc_r <= (acc_r != BYTE_ZERO) ? rel_target : next_pc; // (RULE_01)
            end
            else if (op_r == OP_ACC_ZERO_BRANCH)
            begin
                pc_r <= (acc_r == BYTE_ZERO) ? rel_target : next_pc; // (RULE_03)
            end
            else if (op_r == OP_LONG_CALL || op_r == OP_LONG_JUMP)
            begin
                pc_r <= {b2_r, b3_r}; // (RULE_07) (RULE_08) (RULE_20)
            end
            else
            begin
                pc_r <= next_pc;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data memory and bit writes, decoded combinationally in the execute state.

    always_comb
    begin
        data_raddr_o = b2_r;
        data_we_o = 1'b0;
        data_waddr_o = b2_r;
        data_wdata_o = acc_r;
        bit_addr_o = b2_r;
        bit_we_o = 1'b0;
        bit_wdata_o = carry_r;
        if (op_r[7:3] == GRP_A_REG || op_r[7:3] == GRP_DIR_REG)
        begin
            data_raddr_o = bank_addr(bank_i, op_r);
        end
        else if (ind_form(op_r) && state_r != ST_EXEC)
        begin
            data_raddr_o = ptr_addr(bank_i, op_r);
        end
        else if (op_r[7:1] == GRP_A_IND || op_r[7:1] == GRP_DIR_IND)
        begin
            data_raddr_o = ptr_val_r;
        end
        if (state_r == ST_EXEC && op_r == OP_LONG_CALL)
        begin
            // Two write cycles: low byte at SP+1, then high byte at SP+2.
            data_we_o = 1'b1; // (RULE_06)
            data_waddr_o = sp_r + 8'h01;
            data_wdata_o = code_phase_r ? ret_r[15:8] : ret_r[7:0];
        end
        else if (state_r == ST_EXEC)
        begin
            data_we_o = 1'b1; // (RULE_09) (RULE_10)
            if (op_r[7:3] == GRP_REG_A || op_r[7:3] == GRP_REG_DIR || op_r[7:3] == GRP_REG_IMM)
            begin
                data_waddr_o = bank_addr(bank_i, op_r);
                data_wdata_o = (op_r[7:3] == GRP_REG_A) ? acc_r
                    : (op_r[7:3] == GRP_REG_IMM) ? b2_r : data_rdata_i;
            end
            else if (op_r[7:3] == GRP_DIR_REG || op_r[7:1] == GRP_DIR_IND)
            begin
                data_wdata_o = data_rdata_i;
            end
            else if (op_r == OP_DIR_A)
            begin
                data_wdata_o = acc_r;
            end
            else if (op_r == OP_DIR_DIR)
            begin
                data_waddr_o = b3_r; // (RULE_12)
                data_wdata_o = data_rdata_i;
            end
            else if (op_r == OP_DIR_IMM)
            begin
                data_wdata_o = b3_r;
            end
            else if (op_r[7:1] == GRP_IND_A || op_r[7:1] == GRP_IND_DIR
                || op_r[7:1] == GRP_IND_IMM)
            begin
                // Target is the byte that the pointer register held at operand time.
                data_waddr_o = ptr_val_r;
                data_wdata_o = (op_r[7:1] == GRP_IND_A) ? acc_r
                    : (op_r[7:1] == GRP_IND_IMM) ? b2_r : data_rdata_i;
            end
            else
            begin
                data_we_o = 1'b0;
            end
            bit_we_o = (op_r == OP_BIT_FROM_C); // (RULE_13)
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Architectural registers. Only the instructions named change each one, so
    // both conditional branches leave the accumulator and carry alone.

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            acc_r <= BYTE_ZERO;
            carry_r <= 1'b0;
            data_pointer_r <= PC_RESET;
            sp_r <= SP_RESET;
            invalid_r <= 1'b0;
        end
        else if (state_r == ST_EXEC)
        begin
            if (op_r == OP_LONG_CALL)
            begin
                sp_r <= sp_r + 8'h01; // (RULE_06)
            end
            if (is_table_read && code_phase_r)
            begin
                acc_r <= code_data_i; // (RULE_15)
            end
            else if (op_r == OP_A_DIR && b2_r == ACC_DIRECT_ADDR)
            begin
                invalid_r <= 1'b1; // (RULE_11)
            end
            else if (op_r[7:3] == GRP_A_REG || op_r == OP_A_DIR || op_r[7:1] == GRP_A_IND)
            begin
                acc_r <= data_rdata_i; // (RULE_09)
            end
            else if (op_r == OP_A_IMM)
            begin
                acc_r <= b2_r;
            end
            if (op_r == OP_C_FROM_BIT)
            begin
                carry_r <= bit_rdata_i; // (RULE_13)
            end
            if (op_r == OP_POINTER_LOAD)
            begin
                data_pointer_r <= {b2_r, b3_r}; // (RULE_14)
            end
            if (!op_known)
            begin
                invalid_r <= 1'b1;
            end
        end
    end

    // (RULE_04) Branch opcodes write none of the registers above.
    assign accumulator_o = acc_r;
    assign carry_o = carry_r;
    assign data_pointer_o = data_pointer_r;
    assign stack_pointer_o = sp_r;
    assign pc_o = pc_r;
    assign invalid_o = invalid_r;
endmodule

// ### bench/branch_move_exec_sva.sv
/*
 * Port-level checks for the branch, call and move execution block.
 * Assumes it is bound to the top design module and sees only its ports.
 */
`timescale 1ns/100ps
module branch_move_exec_sva
    import exec_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [15:0] code_addr_o,
    input wire logic [7:0] code_data_i,
    input wire logic [7:0] data_raddr_o,
    input wire logic [7:0] data_rdata_i,
    input wire logic data_we_o,
    input wire logic [7:0] data_waddr_o,
    input wire logic [7:0] data_wdata_o,
    input wire logic [7:0] bit_addr_o,
    input wire logic bit_rdata_i,
    input wire logic bit_we_o,
    input wire logic bit_wdata_o,
    input wire logic [1:0] bank_i,
    input wire logic [7:0] accumulator_o,
    input wire logic carry_o,
    input wire logic [15:0] data_pointer_o,
    input wire logic [7:0] stack_pointer_o,
    input wire logic [15:0] pc_o,
    input wire logic invalid_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    chk_reset_state: assert property ($fell(rst_i) |-> pc_o == PC_RESET &&
        stack_pointer_o == SP_RESET && accumulator_o == BYTE_ZERO && !invalid_o)
        else $error("state not cleared by reset");
    chk_fetch_start: assert property ($fell(rst_i) |-> code_addr_o == pc_o)
        else $error("first fetch not at program counter");
    chk_invalid_kept: assert property (invalid_o |=> invalid_o)
        else $error("invalid flag dropped");
    chk_stack_step: assert property ($changed(stack_pointer_o) |->
        (stack_pointer_o - $past(stack_pointer_o)) inside {8'h01, 8'h02})
        else $error("stack pointer moved by a wrong amount");
    chk_call_quiet: assert property ($changed(stack_pointer_o) |->
        $stable(accumulator_o) && $stable(data_pointer_o) && $stable(carry_o))
        else $error("call disturbed other state");
    chk_pointer_quiet: assert property ($changed(data_pointer_o) |->
        $stable(accumulator_o) && $stable(stack_pointer_o) && $stable(carry_o))
        else $error("pointer load disturbed other state");
    chk_acc_quiet: assert property ($changed(accumulator_o) |->
        $stable(stack_pointer_o) && $stable(data_pointer_o))
        else $error("accumulator write disturbed other state");
    chk_bit_carry: assert property (bit_we_o |-> bit_wdata_o == carry_o && !data_we_o)
        else $error("bit write does not carry the carry flag");
    chk_bit_pulse: assert property (bit_we_o |=> !bit_we_o && $stable(carry_o))
        else $error("bit write not a single pulse");
endmodule

// ### bench/code_data_model.sv
/*
 * Program memory with one cycle of read latency, internal data memory and
 * bit space with same-cycle reads. Assumes the bench preloads the arrays.
 */
`timescale 1ns/100ps
module code_data_model
(
    input wire logic sys_clk_i,
    input wire logic [15:0] code_addr_i,
    output logic [7:0] code_data_o,
    input wire logic [7:0] data_raddr_i,
    output logic [7:0] data_rdata_o,
    input wire logic data_we_i,
    input wire logic [7:0] data_waddr_i,
    input wire logic [7:0] data_wdata_i,
    input wire logic [7:0] bit_addr_i,
    output logic bit_rdata_o,
    input wire logic bit_we_i,
    input wire logic bit_wdata_i
);
    logic [7:0] code [0:65535];
    logic [7:0] dmem [0:255];
    logic bits [0:255];
    // Reads are plain look-ups; unplaced code bytes hold zero, data and bit places hold random bench data.
    always @(posedge sys_clk_i)
    begin
        code_data_o <= code[code_addr_i];
        if (data_we_i)
            dmem[data_waddr_i] <= data_wdata_i;
        if (bit_we_i)
            bits[bit_addr_i] <= bit_wdata_i;
    end
    assign data_rdata_o = dmem[data_raddr_i];
    assign bit_rdata_o = bits[bit_addr_i];
endmodule

// ### bench/cpu_branch_call_move_exec_tb_top.sv
/*
 * Self-checking bench: small programs run from a model memory and the end
 * state is compared with values worked out here. Assumes a 100 MHz clock.
 */
`timescale 1ns/100ps
module cpu_branch_call_move_exec_tb_top;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [1:0] bank_i = 2'b00;
    logic [15:0] code_addr_o, data_pointer_o, pc_o;
    logic [7:0] code_data_i, data_raddr_o, data_rdata_i, data_waddr_o, data_wdata_o;
    logic [7:0] bit_addr_o, accumulator_o, stack_pointer_o;
    logic data_we_o, bit_rdata_i, bit_we_o, bit_wdata_o, carry_o, invalid_o;
    int err_total = 0;
    int samples_checked = 0;
    int seed = 87554;
    logic [7:0] exp_mem [0:255];
    logic [7:0] e_acc, e_sp;
    logic [15:0] e_dp;
    logic e_c, e_inv;
    always #5 sys_clk_i = ~sys_clk_i;
    code_data_model u_mem (.sys_clk_i(sys_clk_i), .code_addr_i(code_addr_o),
        .code_data_o(code_data_i), .data_raddr_i(data_raddr_o), .data_rdata_o(data_rdata_i),
        .data_we_i(data_we_o), .data_waddr_i(data_waddr_o), .data_wdata_i(data_wdata_o),
        .bit_addr_i(bit_addr_o), .bit_rdata_o(bit_rdata_i), .bit_we_i(bit_we_o),
        .bit_wdata_i(bit_wdata_o));
    branch_move_exec u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .code_addr_o(code_addr_o),
        .code_data_i(code_data_i), .data_raddr_o(data_raddr_o), .data_rdata_i(data_rdata_i),
        .data_we_o(data_we_o), .data_waddr_o(data_waddr_o), .data_wdata_o(data_wdata_o),
        .bit_addr_o(bit_addr_o), .bit_rdata_i(bit_rdata_i), .bit_we_o(bit_we_o),
        .bit_wdata_o(bit_wdata_o), .bank_i(bank_i), .accumulator_o(accumulator_o),
        .carry_o(carry_o), .data_pointer_o(data_pointer_o), .stack_pointer_o(stack_pointer_o),
        .pc_o(pc_o), .invalid_o(invalid_o));
    ////////////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("%0d compared, %0d wrong", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task put(input logic [15:0] a, input logic [7:0] q[$]);
        foreach (q[i])
            u_mem.code[a + 16'(i)] = q[i];
    endtask
    // Data and bit memories are refilled with random data and code memory with zeros, so stale values cannot pass by luck.
    task begin_test;
        int i;
        rst_i <= 1'b1;
        bank_i <= 2'($random(seed));
        for (i = 0; i < 65536; i++)
            u_mem.code[i] = 8'h00;
        for (i = 0; i < 256; i++)
        begin
            exp_mem[i] = 8'($random(seed));
            u_mem.dmem[i] = exp_mem[i];
            u_mem.bits[i] = 1'($random(seed));
        end
        u_mem.bits[5] = 1'b1;
        e_acc = 8'h00;
        e_sp = 8'h07;
        e_dp = 16'h0000;
        e_c = 1'b0;
        e_inv = 1'b0;
        repeat (10) @(posedge sys_clk_i);
    endtask
    // Every program ends in a jump to itself, so reaching that address means done.
    task run_and_check(input logic [15:0] end_pc, input string name);
        int n;
        int i;
        n = 0;
        rst_i <= 1'b0;
        while (pc_o !== end_pc && n < 400)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        repeat (10) @(posedge sys_clk_i);
        check(pc_o, end_pc);
        check({8'h00, accumulator_o}, {8'h00, e_acc});
        check({15'h0000, carry_o}, {15'h0000, e_c});
        check(data_pointer_o, e_dp);
        check({8'h00, stack_pointer_o}, {8'h00, e_sp});
        check({15'h0000, invalid_o}, {15'h0000, e_inv});
        for (i = 0; i < 256; i++)
            check({8'h00, u_mem.dmem[i]}, {8'h00, exp_mem[i]});
        $display("test %s finished", name);
    endtask
    initial
    begin
        logic [7:0] r, th, tl, d1, d2, d3, rb;
        begin_test;
        r = 8'($random(seed)) | 8'h01;
        put(16'h0000, '{8'hA2, 8'h05, 8'h74, 8'h00, 8'h70, 8'h03, 8'h60, 8'h03, 8'h74,
            8'h55, 8'h02, 8'h74, r, 8'h70, 8'h11});
        put(16'h0014, '{8'h02, 8'h00, 8'h14});
        put(16'h0020, '{8'h60, 8'h05, 8'h70, 8'hF0});
        e_acc = r;
        e_c = 1'b1;
        run_and_check(16'h0014, "branches");
        begin_test;
        th = 8'h20 + 8'($random(seed) & 8'h7F);
        tl = 8'($random(seed));
        put(16'h0000, '{8'h02, 8'h01, 8'h23});
        put(16'h0123, '{8'h12, th, tl});
        put({th, tl}, '{8'h02, th, tl});
        exp_mem[8'h08] = 8'h26;
        exp_mem[8'h09] = 8'h01;
        e_sp = 8'h09;
        run_and_check({th, tl}, "call and jump");
        begin_test;
        th = 8'h10 + 8'($random(seed) & 8'h7F);
        d1 = 8'($random(seed));
        d2 = 8'($random(seed));
        put(16'h0000, '{8'h90, th, 8'hF8, 8'h74, 8'h10, 8'h93, 8'hF5, 8'h40, 8'h74, 8'h03,
            8'h83, 8'h02, 8'h00, 8'h0B, d2});
        put({th + 8'h01, 8'h08}, '{d1});
        e_acc = d2;
        exp_mem[8'h40] = d1;
        e_dp = {th, 8'hF8};
        run_and_check(16'h000B, "table reads");
        begin_test;
        rb = {3'b000, bank_i, 3'b000};
        d1 = 8'($random(seed));
        d2 = 8'($random(seed));
        d3 = 8'($random(seed));
        put(16'h0000, '{8'h75, 8'h30, d1, 8'h85, 8'h30, 8'h31, 8'hE5, 8'h31, 8'hFD, 8'h7A,
            d2, 8'hEA, 8'h8A, 8'h32, 8'hAB, 8'h30, 8'h79, 8'h40, 8'h77, d3, 8'h78, 8'h41,
            8'hF6, 8'hE7, 8'h86, 8'h33, 8'hA6, 8'h30, 8'hE5, 8'hE0, 8'hA2, 8'h05, 8'h92,
            8'h07, 8'h02, 8'h00, 8'h22});
        exp_mem[8'h30] = d1;
        exp_mem[8'h31] = d1;
        exp_mem[rb + 8'h05] = d1;
        exp_mem[rb + 8'h02] = d2;
        exp_mem[8'h32] = d2;
        exp_mem[rb + 8'h03] = d1;
        exp_mem[rb + 8'h01] = 8'h40;
        exp_mem[8'h40] = d3;
        exp_mem[rb] = 8'h41;
        exp_mem[8'h41] = d1;
        exp_mem[8'h33] = d2;
        e_acc = d3;
        e_c = 1'b1;
        e_inv = 1'b1;
        run_and_check(16'h0022, "byte and bit moves");
        check({15'h0000, u_mem.bits[7]}, 16'h0001);
        close_out;
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        err_total++;
        close_out;
    end
endmodule

bind branch_move_exec branch_move_exec_sva u_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .code_addr_o(code_addr_o), .code_data_i(code_data_i), .data_raddr_o(data_raddr_o),
    .data_rdata_i(data_rdata_i), .data_we_o(data_we_o), .data_waddr_o(data_waddr_o),
    .data_wdata_o(data_wdata_o), .bit_addr_o(bit_addr_o), .bit_rdata_i(bit_rdata_i),
    .bit_we_o(bit_we_o), .bit_wdata_o(bit_wdata_o), .bank_i(bank_i),
    .accumulator_o(accumulator_o), .carry_o(carry_o), .data_pointer_o(data_pointer_o),
    .stack_pointer_o(stack_pointer_o), .pc_o(pc_o), .invalid_o(invalid_o));
